// File: rtl/rx_diag_pkg.sv
// shared constants and types for the per-port diagnostic status bank
package rx_diag_pkg;
    localparam int PORT_COUNT = 4;
    localparam logic [7:0] OFS_PORT_SELECT = 8'h4c;
    localparam logic [7:0] OFS_TEMP_LEVEL = 8'h53;
    localparam logic [7:0] OFS_CSI_FLAGS = 8'h54;
    localparam logic [7:0] OFS_PAR_HIGH = 8'h55;
    localparam logic [7:0] OFS_PAR_LOW = 8'h56;
    localparam logic [7:0] OFS_SELF_TEST = 8'h57;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_PAR_COUNT = 16'h0000;
    localparam logic [7:0] RESET_SELF_TEST = 8'h00;
    localparam logic [2:0] RESET_TEMP = 3'h0;
    localparam logic [4:0] RESET_CSI = 5'h00;
    localparam logic [1:0] RESET_PORT_SEL = 2'h0;
    localparam int CSI_FIELD_WIDTH = 5;
    localparam int TEMP_FIELD_WIDTH = 3;

    // status frame delivered by the forward channel of one port
    typedef struct packed {
        logic valid;
        logic [2:0] tempLevel;
        logic remoteDoubleEccFlag;
        logic remoteChecksumFlag;
        logic remoteStartOfTransmissionFlag;
        logic remoteSyncFlag;
        logic remoteControlFlag;
    } remote_status_t;

    // per-port event strobes from the receiver
    typedef struct packed {
        logic parityError;
        logic lockAcquired;
        logic selfTestError;
    } link_events_t;

    // host register access strobe bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;
endpackage

// File: rtl/rx_port_diag_status.sv
// per receive port diagnostic status bank with port-selected host access
`timescale 1ns/1ps
`default_nettype none

module rx_port_diag_status
    import rx_diag_pkg::*;
#(
    parameter int PORTS = PORT_COUNT
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire reg_access_t hostAccess,
    input wire remote_status_t remoteStatus [PORTS],
    input wire link_events_t linkEvents [PORTS],
    output logic [7:0] readData,
    output logic readValid
);

    ////////////////////////////////////////////////////////////////////////
    typedef logic [$clog2(PORTS)-1:0] port_idx_t;

    function automatic logic [15:0] satInc16(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    function automatic logic [7:0] satInc8(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    port_idx_t portSel_q, portSel_d;
    logic [2:0] temp_q [PORTS];
    logic [2:0] temp_d [PORTS];
    logic [4:0] csi_q [PORTS];
    logic [4:0] csi_d [PORTS];
    logic [15:0] par_q [PORTS];
    logic [15:0] par_d [PORTS];
    logic [7:0] bist_q [PORTS];
    logic [7:0] bist_d [PORTS];
    logic [7:0] readData_q, readData_d;
    logic readValid_q, readValid_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        portSel_d = portSel_q;
        readData_d = RESET_BYTE;
        readValid_d = hostAccess.rd;
        // port select is the only host-writable register here
        if (hostAccess.wr && hostAccess.addr == OFS_PORT_SELECT) begin
            portSel_d = port_idx_t'(hostAccess.wdata);
        end
        if (hostAccess.rd) begin
            case (hostAccess.addr)
                OFS_PORT_SELECT: readData_d = 8'(portSel_q);
                OFS_TEMP_LEVEL: readData_d = {5'h00, temp_q[portSel_q]};
                OFS_CSI_FLAGS: readData_d = {3'h0, csi_q[portSel_q]};
                OFS_PAR_HIGH: readData_d = par_q[portSel_q][15:8];
                OFS_PAR_LOW: readData_d = par_q[portSel_q][7:0];
                OFS_SELF_TEST: readData_d = bist_q[portSel_q];
                default: readData_d = RESET_BYTE;
            endcase
        end
        for (int p = 0; p < PORTS; p++) begin
            temp_d[p] = temp_q[p];
            csi_d[p] = csi_q[p];
            par_d[p] = par_q[p];
            bist_d[p] = bist_q[p];
            // host writes never reach the mirrored status
            if (remoteStatus[p].valid) begin
                temp_d[p] = remoteStatus[p].tempLevel;
                csi_d[p] = {remoteStatus[p].remoteDoubleEccFlag,
                    remoteStatus[p].remoteChecksumFlag,
                    remoteStatus[p].remoteStartOfTransmissionFlag,
                    remoteStatus[p].remoteSyncFlag,
                    remoteStatus[p].remoteControlFlag};
            end
            // clear by lock or low-byte read, then the same-cycle error still counts
            if (linkEvents[p].lockAcquired) begin
                par_d[p] = RESET_PAR_COUNT;
            end
            if (hostAccess.rd && hostAccess.addr == OFS_PAR_LOW
                && portSel_q == port_idx_t'(p)) begin
                par_d[p] = RESET_PAR_COUNT;
            end
            if (linkEvents[p].parityError) begin
                par_d[p] = satInc16(par_d[p]);
            end
            if (linkEvents[p].selfTestError) begin
                bist_d[p] = satInc8(bist_q[p]);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            portSel_q <= port_idx_t'(RESET_PORT_SEL);
            readData_q <= RESET_BYTE;
            readValid_q <= 1'b0;
            for (int p = 0; p < PORTS; p++) begin
                temp_q[p] <= RESET_TEMP;
                csi_q[p] <= RESET_CSI;
                par_q[p] <= RESET_PAR_COUNT;
                bist_q[p] <= RESET_SELF_TEST;
            end
        end else begin
            portSel_q <= portSel_d;
            readData_q <= readData_d;
            readValid_q <= readValid_d;
            for (int p = 0; p < PORTS; p++) begin
                temp_q[p] <= temp_d[p];
                csi_q[p] <= csi_d[p];
                par_q[p] <= par_d[p];
                bist_q[p] <= bist_d[p];
            end
        end
    end

    assign readData = readData_q;
    assign readValid = readValid_q;

    ////////////////////////////////////////////////////////////////////////
    // per-port count and status checks watch port 0, except the self-test saturation check on port PORTS-1; read checks use the port in portSel_q
    property p_portWrite;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.wr && hostAccess.addr == OFS_PORT_SELECT
        |=> portSel_q == $past(port_idx_t'(hostAccess.wdata));
    endproperty
    a_portWrite: assert property (p_portWrite) else $error("port select not stored");

    property p_remoteLoad;
        @(posedge clk_sys) disable iff (!rstn)
        remoteStatus[0].valid |=> temp_q[0] == $past(remoteStatus[0].tempLevel);
    endproperty
    a_remoteLoad: assert property (p_remoteLoad) else $error("temp not loaded");

    property p_noRemoteHold;
        @(posedge clk_sys) disable iff (!rstn)
        !remoteStatus[0].valid |=> $stable(csi_q[0]) && $stable(temp_q[0]);
    endproperty
    a_noRemoteHold: assert property (p_noRemoteHold) else $error("status changed alone");

    property p_tempRead;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_TEMP_LEVEL
        |=> readValid && readData[7:3] == 5'h00;
    endproperty
    a_tempRead: assert property (p_tempRead) else $error("temp reserved bits set");

    property p_csiRead;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_CSI_FLAGS && !hostAccess.wr
        |=> readData == {3'h0, $past(csi_q[portSel_q])};
    endproperty
    a_csiRead: assert property (p_csiRead) else $error("csi flags wrong");

    property p_lowClear;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_PAR_LOW && portSel_q == '0
        && !linkEvents[0].parityError |=> par_q[0] == 16'h0000;
    endproperty
    a_lowClear: assert property (p_lowClear) else $error("low read did not clear");

    property p_highKeep;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_PAR_HIGH && !linkEvents[0].parityError
        && !linkEvents[0].lockAcquired |=> $stable(par_q[0]);
    endproperty
    a_highKeep: assert property (p_highKeep) else $error("high read changed count");

    property p_lockRestart;
        @(posedge clk_sys) disable iff (!rstn)
        linkEvents[0].lockAcquired && !linkEvents[0].parityError |=> par_q[0] == 16'h0000;
    endproperty
    a_lockRestart: assert property (p_lockRestart) else $error("lock did not restart");

    property p_parSat;
        @(posedge clk_sys) disable iff (!rstn)
        par_q[0] == 16'hffff && !linkEvents[0].lockAcquired
        && !(hostAccess.rd && hostAccess.addr == OFS_PAR_LOW) |=> par_q[0] == 16'hffff;
    endproperty
    a_parSat: assert property (p_parSat) else $error("parity count wrapped");

    property p_bistCount;
        @(posedge clk_sys) disable iff (!rstn)
        linkEvents[0].selfTestError && bist_q[0] != 8'hff
        |=> bist_q[0] == $past(bist_q[0]) + 8'h01;
    endproperty
    a_bistCount: assert property (p_bistCount) else $error("self-test count wrong");

    property p_highRead;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_PAR_HIGH
        |=> readData == $past(par_q[portSel_q][15:8]);
    endproperty
    a_highRead: assert property (p_highRead) else $error("parity high byte wrong");

    property p_lowRead;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_PAR_LOW
        |=> readData == $past(par_q[portSel_q][7:0]);
    endproperty
    a_lowRead: assert property (p_lowRead) else $error("parity low byte wrong");

    property p_selfTestRead;
        @(posedge clk_sys) disable iff (!rstn)
        hostAccess.rd && hostAccess.addr == OFS_SELF_TEST
        |=> readData == $past(bist_q[portSel_q]);
    endproperty
    a_selfTestRead: assert property (p_selfTestRead) else $error("self-test read wrong");

    // only reset may lower a saturated self-test count
    property p_bistSat;
        @(posedge clk_sys) disable iff (!rstn)
        bist_q[PORTS-1] == 8'hff |=> bist_q[PORTS-1] == 8'hff;
    endproperty
    a_bistSat: assert property (p_bistSat) else $error("self-test count wrapped");

endmodule

`default_nettype wire

// File: test/rx_port_diag_status_tb.sv
// self-checking bench for the per-port diagnostic status bank
`timescale 1ns/1ps
`default_nettype none
module rx_port_diag_status_tb import rx_diag_pkg::*;;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    reg_access_t hostAccess = '0;
    remote_status_t remoteStatus [PORT_COUNT];
    link_events_t linkEvents [PORT_COUNT];
    logic [7:0] readData;
    logic readValid;
    int nFail = 0;
    int checkCount = 0;
    int cycles = 0;
    int n;
    remote_status_t frame;
    always #25 clk_sys = ~clk_sys;
    rx_port_diag_status #(.PORTS(PORT_COUNT)) rx_port_diag_status_inst (
        .clk_sys(clk_sys), .rstn(rstn), .hostAccess(hostAccess),
        .remoteStatus(remoteStatus), .linkEvents(linkEvents),
        .readData(readData), .readValid(readValid));
    serializer_model serializer_model_inst (
        .clk_sys(clk_sys), .remoteStatus(remoteStatus), .linkEvents(linkEvents));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] sat(input int v, input int w);
        return (v >= (1 << w)) ? 16'((1 << w) - 1) : 16'(v);
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // strobes stay up so reads run back to back; caller drops them
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        hostAccess = {1'b0, 1'b1, a, d};
        @(negedge clk_sys);
    endtask
    task automatic regRead(input logic [7:0] a, input logic [7:0] exp, input string what);
        hostAccess = {1'b1, 1'b0, a, 8'h00};
        @(negedge clk_sys);
        check({what, " valid"}, 8'h01, {7'h00, readValid});
        check(what, exp, readData);
    endtask
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            nFail++;
            endOfTest();
        end
    end
    initial begin
        void'($urandom(70));
        repeat (16) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        for (int p = 0; p < PORT_COUNT; p++) begin
            regWrite(OFS_PORT_SELECT, 8'(p));
            regRead(OFS_PORT_SELECT, 8'(p), "port select");
            regRead(OFS_SELF_TEST, RESET_SELF_TEST, "self test reset");
            regRead(8'h60, 8'h00, "unmapped");
            hostAccess = '0;
            frame = 9'($urandom);
            serializer_model_inst.sendFrame(p, frame);
            regWrite(OFS_TEMP_LEVEL, 8'hff);
            regRead(OFS_TEMP_LEVEL, {5'h00, frame.tempLevel}, "temperature");
            regRead(OFS_CSI_FLAGS, {3'h0, frame.remoteDoubleEccFlag, frame.remoteChecksumFlag,
                frame.remoteStartOfTransmissionFlag, frame.remoteSyncFlag,
                frame.remoteControlFlag}, "csi flags");
            hostAccess = '0;
            // port 2 and up cross the low byte and saturate the self-test count
            n = p * 130 + $urandom_range(40, 1);
            serializer_model_inst.raiseEvents(p, 3'b101, n);
            regRead(OFS_PAR_HIGH, 8'(sat(n, 16) >> 8), "parity high");
            regRead(OFS_PAR_HIGH, 8'(sat(n, 16) >> 8), "parity high again");
            regRead(OFS_PAR_LOW, 8'(sat(n, 16)), "parity low");
            regRead(OFS_PAR_LOW, 8'h00, "parity low cleared");
            regRead(OFS_PAR_HIGH, 8'h00, "parity high cleared");
            regRead(OFS_SELF_TEST, 8'(sat(n, 8)), "self test");
            hostAccess = '0;
        end
        // lock and parity saturation corners run on port 0, where the assertions look; the saturated self-test check after reset uses port 3
        regWrite(OFS_PORT_SELECT, 8'h00);
        hostAccess = '0;
        serializer_model_inst.raiseEvents(0, 3'b100, 5);
        serializer_model_inst.raiseEvents(0, 3'b010, 1);
        regRead(OFS_PAR_LOW, 8'h00, "parity after bare lock");
        hostAccess = '0;
        serializer_model_inst.raiseEvents(0, 3'b100, 5);
        serializer_model_inst.raiseEvents(0, 3'b110, 1);
        regRead(OFS_PAR_LOW, 8'h01, "parity after lock");
        hostAccess = '0;
        serializer_model_inst.raiseEvents(0, 3'b100, 65540);
        regWrite(OFS_PAR_LOW, 8'h00);
        regRead(OFS_PAR_HIGH, 8'hff, "parity saturated high");
        regRead(OFS_PAR_LOW, 8'hff, "parity saturated low");
        hostAccess = '0;
        rstn = 1'b0;
        @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        regRead(OFS_PORT_SELECT, 8'h00, "select after reset");
        regRead(OFS_SELF_TEST, 8'h00, "self test after reset");
        regWrite(OFS_PORT_SELECT, 8'h03);
        regRead(OFS_SELF_TEST, RESET_SELF_TEST, "saturated self test after reset");
        regRead(OFS_TEMP_LEVEL, {5'h00, RESET_TEMP}, "temperature after reset");
        hostAccess = '0;
        @(negedge clk_sys);
        check("idle valid", 8'h00, {7'h00, readValid});
        check("idle data", 8'h00, readData);
        endOfTest();
    end
endmodule
`default_nettype wire

// File: test/serializer_model.sv
// remote serializer model: status frames and receiver events per port
`timescale 1ns/1ps
`default_nettype none
module serializer_model
    import rx_diag_pkg::*;
(
    input wire logic clk_sys,
    output var remote_status_t remoteStatus [PORT_COUNT],
    output var link_events_t linkEvents [PORT_COUNT]
);
    initial begin
        foreach (remoteStatus[i]) begin
            remoteStatus[i] = '0;
            linkEvents[i] = '0;
        end
    end
    // one valid cycle; then the fields turn inverted so stale data never matches
    task automatic sendFrame(input int p, input remote_status_t f);
        remote_status_t s;
        s = f;
        s.valid = 1'b1;
        @(negedge clk_sys);
        remoteStatus[p] = s;
        s = ~f;
        s.valid = 1'b0;
        @(negedge clk_sys);
        remoteStatus[p] = s;
    endtask
    // hold the event strobes for n clock cycles
    task automatic raiseEvents(input int p, input link_events_t e, input int n);
        @(negedge clk_sys);
        linkEvents[p] = e;
        repeat (n) @(negedge clk_sys);
        // strobes drop before the bench reads a count, like a host idling the checker
        linkEvents[p] = '0;
    endtask
endmodule
`default_nettype wire
